// ---- design/fcs_pkg.sv ----
package fcs_pkg;

  // Flash bus geometry (byte mode)
  localparam int ADDR_W = 22;
  localparam int DATA_W = 8;

  // Unlock addresses and codes
  localparam logic [11:0] UNLOCK_A1   = 12'haaa;
  localparam logic [11:0] UNLOCK_A2   = 12'h555;
  localparam logic [7:0]  UNLOCK_D1   = 8'haa;
  localparam logic [7:0]  UNLOCK_D2   = 8'h55;
  localparam logic [7:0]  CMD_RESET   = 8'hf0;
  localparam logic [7:0]  CMD_AUTOSEL = 8'h90;
  localparam logic [7:0]  CMD_PROG    = 8'ha0;
  localparam logic [7:0]  CMD_ERASE   = 8'h80;
  localparam logic [7:0]  CMD_CHIP    = 8'h10;
  localparam logic [7:0]  CMD_SECT    = 8'h30;
  localparam logic [7:0]  CMD_WBUF    = 8'h25;
  localparam logic [7:0]  CMD_COMMIT  = 8'h29;
  localparam logic [7:0]  CMD_SUSPEND = 8'hb0;
  localparam logic [7:0]  CMD_RESUME  = 8'h30;
  localparam logic [7:0]  CMD_EXIT0   = 8'h00;
  localparam logic [7:0]  CMD_PW_ENT  = 8'h60;
  localparam logic [7:0]  CMD_PPB_ENT = 8'hc0;
  localparam logic [7:0]  CMD_DYB_ENT = 8'he0;

  // Autoselect read addresses
  localparam logic [7:0] AS_MFR  = 8'h00;
  localparam logic [7:0] AS_DEV1 = 8'h02;
  localparam logic [7:0] AS_DEV2 = 8'h1c;
  localparam logic [7:0] AS_DEV3 = 8'h1e;
  localparam logic [7:0] AS_PROT = 8'h04;

  // Sector field of the address and write buffer limits
  localparam int SECT_LSB  = 15;
  localparam int WBUF_MAX  = 32;
  localparam int SEQ_MAX   = 37;
  localparam int PW_BYTES  = 8;

  // Bus cycle timing, 100 ns clock
  localparam int CLK_NS     = 100;
  localparam int STROBE_NS  = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);

  typedef enum logic [4:0] {
    FCS_OP_RESET    = 5'h00,
    FCS_OP_READ     = 5'h01,
    FCS_OP_PROG     = 5'h02,
    FCS_OP_WBUF     = 5'h03,
    FCS_OP_ABORT    = 5'h04,
    FCS_OP_CHIP_ER  = 5'h05,
    FCS_OP_SECT_ER  = 5'h06,
    FCS_OP_SUSPEND  = 5'h07,
    FCS_OP_RESUME   = 5'h08,
    FCS_OP_ID       = 5'h09,
    FCS_OP_PROT_VFY = 5'h0a,
    FCS_OP_PW_PROG  = 5'h0b,
    FCS_OP_PW_READ  = 5'h0c,
    FCS_OP_PW_UNLK  = 5'h0d,
    FCS_OP_PPB_PROG = 5'h0e,
    FCS_OP_PPB_ERA  = 5'h0f,
    FCS_OP_DYB_SET  = 5'h10,
    FCS_OP_DYB_CLR  = 5'h11
  } fcs_op_e;

  typedef struct packed {
    fcs_op_e             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
    logic [5:0]          count;
  } fcs_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              we;
  } fcs_cyc_s;

endpackage

// ---- design/fcs_bus_cycle.sv ----
`timescale 1ns/1ps
module fcs_bus_cycle
  import fcs_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // Cycle request
  input  wire logic                   cyc_valid,
  output logic                        cyc_ready,
  input  wire fcs_pkg::fcs_cyc_s      cyc,
  output logic                        cyc_done,
  output logic [fcs_pkg::DATA_W-1:0]  cyc_rdata,
  // Flash pins
  output logic [fcs_pkg::ADDR_W-1:0]  flash_addr,
  output logic                        flash_ce_n,
  output logic                        flash_we_n,
  output logic                        flash_oe_n,
  output logic [fcs_pkg::DATA_W-1:0]  flash_dq_out,
  output logic                        flash_dq_oe,
  input  wire logic [fcs_pkg::DATA_W-1:0] flash_dq_in
);
  import fcs_pkg::*;

  // Phases: setup (addr/ce), strobe low, release (data held past rise)
  typedef enum logic [1:0] {
    FCS_BC_IDLE  = 2'b00,
    FCS_BC_SETUP = 2'b01,
    FCS_BC_STRB  = 2'b10,
    FCS_BC_HOLD  = 2'b11
  } fcs_bc_e;

  fcs_bc_e                state;
  logic [3:0]             cnt;
  logic                   is_write;
  logic [DATA_W-1:0]      dq_s1;
  logic [DATA_W-1:0]      dq_s2;

  assign cyc_ready = (state == FCS_BC_IDLE);
  wire   strobe_end = (state == FCS_BC_STRB) && (cnt == 4'h0);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end
    else
    begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state        <= FCS_BC_IDLE;
      cnt          <= '0;
      is_write     <= 1'b0;
      flash_addr   <= '0;
      flash_dq_out <= '0;
      flash_ce_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
      flash_dq_oe  <= 1'b1;
      cyc_done     <= 1'b0;
      cyc_rdata    <= '0;
    end
    else
    begin
      cyc_done <= 1'b0;
      unique case (state)
        FCS_BC_IDLE:
        begin
          if (cyc_valid)
          begin
            // Address settles with CE before WE falls, so the later falling edge latches it
            flash_addr   <= cyc.addr; // [RULE8]
            flash_dq_out <= cyc.data;
            is_write     <= cyc.we;
            flash_ce_n   <= 1'b0;
            flash_dq_oe  <= ~cyc.we;
            state        <= FCS_BC_SETUP;
          end
        end
        FCS_BC_SETUP:
        begin
          flash_we_n <= ~is_write;
          flash_oe_n <= is_write;
          cnt        <= STROBE_CNT + 4'h1;
          state      <= FCS_BC_STRB;
        end
        FCS_BC_STRB:
        begin
          cnt <= cnt - 4'h1;
          if (strobe_end)
          begin
            // WE rises before CE; data still driven on that earlier rise
            flash_we_n <= 1'b1; // [RULE9]
            flash_oe_n <= 1'b1;
            cyc_rdata  <= dq_s2;
            state      <= FCS_BC_HOLD;
          end
        end
        FCS_BC_HOLD:
        begin
          flash_ce_n  <= 1'b1;
          flash_dq_oe <= 1'b1;
          cyc_done    <= 1'b1;
          state       <= FCS_BC_IDLE;
        end
      endcase
    end
  end

  a_we_inside_ce: assert property (@(posedge clock) disable iff (rst) // [RULE8]
    !flash_we_n |-> !flash_ce_n)
    else $error("write strobe low outside chip select");
  a_data_held_rise: assert property (@(posedge clock) disable iff (rst) // [RULE9]
    ($rose(flash_we_n) && is_write) |-> (!flash_dq_oe && $stable(flash_dq_out)))
    else $error("data not driven at write strobe rise");

endmodule // fcs_bus_cycle

// ---- design/fcs_flash_host.sv ----
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Reset command after bad sequence
// [RULE2] Exit protection modes with 90 then 00
// [RULE3] Full two writes per password byte
// [RULE4] Password read drives full address
// [RULE5] Unlock sends every password byte
// [RULE6] Hold accelerate high while setting bits
// [RULE7] Device preprograms before bulk protect erase
// [RULE8] Address latched at later falling edge
// [RULE9] Data latched at earlier rising edge
// [RULE10] Sector chosen by upper address bits
// [RULE11] Buffer writes stay in one page
// [RULE12] Count written is locations minus one; the password unlock writes 03 and then 8 password bytes
// [RULE13] Unlock addresses ignore bits above A11
// [RULE14] Buffer sequence at most 37 writes
// [RULE15] Reset leaves autoselect or timeout
// [RULE16] Autoselect fourth cycle is a read
// [RULE17] Identification read in three cycles
// [RULE18] Protect verify reads zero or one
// [RULE19] Three-write abort reset after buffer abort
// [RULE20] Commit code written to target sector
// [RULE21] Suspend only during sector erase
// [RULE22] Resume only while suspended
module fcs_flash_host
  import fcs_pkg::*;
#(
  parameter int BUF_DEPTH = fcs_pkg::WBUF_MAX
)
(
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // User request
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire fcs_pkg::fcs_req_s          req,
  // Buffer and password bytes, one per data bus cycle (wdata_take)
  input  wire logic [fcs_pkg::DATA_W-1:0] wdata,
  output logic                            wdata_take,
  // Results
  output logic                            rsp_valid,
  output logic [fcs_pkg::DATA_W-1:0]      rsp_data,
  output logic                            rsp_error,
  output logic                            erase_busy,
  output logic                            erase_suspended,
  // Flash pins
  output logic [fcs_pkg::ADDR_W-1:0]      flash_addr,
  output logic                            flash_ce_n,
  output logic                            flash_we_n,
  output logic                            flash_oe_n,
  output logic [fcs_pkg::DATA_W-1:0]      flash_dq_out,
  output logic                            flash_dq_oe,
  input  wire logic [fcs_pkg::DATA_W-1:0] flash_dq_in,
  output logic                            accel_input
);
  import fcs_pkg::*;

  typedef enum logic [1:0] {
    FCS_IDLE = 2'b00,
    FCS_RUN  = 2'b01,
    FCS_WAIT = 2'b10
  } fcs_st_e;

  fcs_st_e            state;
  fcs_req_s           cur;
  logic [5:0]         step;
  logic [5:0]         last_step;
  logic               cyc_valid;
  logic               cyc_ready;
  logic               cyc_done;
  logic [DATA_W-1:0]  cyc_rdata;
  fcs_cyc_s           cyc;

  wire [ADDR_W-1:0] u1 = {{(ADDR_W-12){1'b0}}, UNLOCK_A1}; // [RULE13]
  wire [ADDR_W-1:0] u2 = {{(ADDR_W-12){1'b0}}, UNLOCK_A2}; // [RULE13]
  wire [ADDR_W-1:0] sect_base = {cur.addr[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}}; // [RULE10]
  wire [ADDR_W-1:0] page_base = cur.addr & ~ADDR_W'(BUF_DEPTH - 1);
  wire [5:0]        cnt_lim = (cur.count >= 6'(BUF_DEPTH)) ? 6'(BUF_DEPTH - 1) : cur.count;
  // First data beat lands on the program address, later ones wrap inside its page
  wire [ADDR_W-1:0] buf_addr = page_base | ADDR_W'((cur.addr + ADDR_W'(step - 6'd4)) & ADDR_W'(BUF_DEPTH - 1)); // [RULE11]
  wire [ADDR_W-1:0] unk_addr = ADDR_W'(step - 6'd5);

  // Suspend/resume refused unless the erase state allows them
  wire op_legal = !((req.op == FCS_OP_SUSPEND) && !(erase_busy && !erase_suspended)) // [RULE21]
                && !((req.op == FCS_OP_RESUME) && !erase_suspended); // [RULE22]

  // Last step index per operation; entry (3) plus body plus exit (2) for protection sets
  always_comb
  begin
    unique case (cur.op)
      FCS_OP_RESET, FCS_OP_READ, FCS_OP_SUSPEND, FCS_OP_RESUME: last_step = 6'd0;
      FCS_OP_PROG:                     last_step = 6'd3;
      FCS_OP_ABORT:                    last_step = 6'd2;  // [RULE19]
      FCS_OP_CHIP_ER, FCS_OP_SECT_ER:  last_step = 6'd5;
      FCS_OP_WBUF:                     last_step = 6'd5 + cnt_lim; // [RULE14]
      FCS_OP_ID:                       last_step = 6'd6;  // [RULE17]
      FCS_OP_PROT_VFY:                 last_step = 6'd4;
      FCS_OP_PW_PROG:                  last_step = 6'd6;
      FCS_OP_PW_READ:                  last_step = 6'd5;
      FCS_OP_PW_UNLK:                  last_step = 6'd15; // [RULE5]
      default:                         last_step = 6'd6;
    endcase
  end

  // Sequence generator: one bus cycle per step
  always_comb
  begin
    cyc = '{addr: '0, data: '0, we: 1'b1};
    if (step == 6'd0 && cur.op != FCS_OP_RESET && cur.op != FCS_OP_READ
        && cur.op != FCS_OP_SUSPEND && cur.op != FCS_OP_RESUME)
      cyc = '{addr: u1, data: UNLOCK_D1, we: 1'b1};
    else if (step == 6'd1)
      cyc = '{addr: u2, data: UNLOCK_D2, we: 1'b1};
    else
    begin
      unique case (cur.op)
        FCS_OP_RESET:   cyc = '{addr: '0, data: CMD_RESET, we: 1'b1}; // [RULE1] [RULE15]
        FCS_OP_READ:    cyc = '{addr: cur.addr, data: '0, we: 1'b0};
        FCS_OP_SUSPEND: cyc = '{addr: '0, data: CMD_SUSPEND, we: 1'b1};
        FCS_OP_RESUME:  cyc = '{addr: '0, data: CMD_RESUME, we: 1'b1};
        FCS_OP_PROG:    cyc = (step == 6'd2) ? '{addr: u1, data: CMD_PROG, we: 1'b1}
                                             : '{addr: cur.addr, data: cur.data, we: 1'b1};
        FCS_OP_ABORT:   cyc = '{addr: u1, data: CMD_RESET, we: 1'b1}; // [RULE19]
        FCS_OP_CHIP_ER, FCS_OP_SECT_ER:
          case (step)
            6'd2:    cyc = '{addr: u1, data: CMD_ERASE, we: 1'b1};
            6'd3:    cyc = '{addr: u1, data: UNLOCK_D1, we: 1'b1};
            6'd4:    cyc = '{addr: u2, data: UNLOCK_D2, we: 1'b1};
            default: cyc = (cur.op == FCS_OP_CHIP_ER) ? '{addr: u1, data: CMD_CHIP, we: 1'b1}
                                                      : '{addr: sect_base, data: CMD_SECT, we: 1'b1};
          endcase
        FCS_OP_WBUF:
          if (step == 6'd2)      cyc = '{addr: sect_base, data: CMD_WBUF, we: 1'b1};
          else if (step == 6'd3) cyc = '{addr: sect_base, data: 8'(cnt_lim), we: 1'b1}; // [RULE12]
          else if (step == last_step) cyc = '{addr: sect_base, data: CMD_COMMIT, we: 1'b1}; // [RULE20]
          else                   cyc = '{addr: buf_addr, data: wdata, we: 1'b1};
        FCS_OP_ID:
          case (step)
            6'd2:    cyc = '{addr: u1, data: CMD_AUTOSEL, we: 1'b1};
            6'd3:    cyc = '{addr: ADDR_W'(AS_DEV1), data: '0, we: 1'b0}; // [RULE16]
            6'd4:    cyc = '{addr: ADDR_W'(AS_DEV2), data: '0, we: 1'b0};
            6'd5:    cyc = '{addr: ADDR_W'(AS_DEV3), data: '0, we: 1'b0};
            6'd6:    cyc = '{addr: '0, data: CMD_RESET, we: 1'b1}; // [RULE15]
            default: cyc = '{addr: '0, data: CMD_RESET, we: 1'b1};
          endcase
        FCS_OP_PROT_VFY:
          case (step)
            6'd2:    cyc = '{addr: u1, data: CMD_AUTOSEL, we: 1'b1};
            6'd3:    cyc = '{addr: sect_base | ADDR_W'(AS_PROT), data: '0, we: 1'b0}; // [RULE18]
            default: cyc = '{addr: '0, data: CMD_RESET, we: 1'b1}; // [RULE15]
          endcase
        default:
          // Protection command sets: entry, body, exit
          if (step == 6'd2)
            cyc = '{addr: u1, data: (cur.op == FCS_OP_PW_PROG || cur.op == FCS_OP_PW_READ
                    || cur.op == FCS_OP_PW_UNLK) ? CMD_PW_ENT
                    : (cur.op == FCS_OP_PPB_PROG || cur.op == FCS_OP_PPB_ERA) ? CMD_PPB_ENT
                    : CMD_DYB_ENT, we: 1'b1};
          else if (step == last_step - 6'd1)
            cyc = '{addr: '0, data: CMD_AUTOSEL, we: 1'b1}; // [RULE2]
          else if (step == last_step)
            cyc = '{addr: '0, data: CMD_EXIT0, we: 1'b1}; // [RULE2]
          else
            unique case (cur.op)
              FCS_OP_PW_PROG: cyc = (step == 6'd3) ? '{addr: '0, data: CMD_PROG, we: 1'b1}
                                                   : '{addr: cur.addr, data: cur.data, we: 1'b1}; // [RULE3]
              FCS_OP_PW_READ: cyc = '{addr: cur.addr, data: '0, we: 1'b0}; // [RULE4]
              FCS_OP_PPB_ERA: cyc = (step == 6'd3) ? '{addr: '0, data: CMD_ERASE, we: 1'b1}
                                                   : '{addr: '0, data: CMD_SECT, we: 1'b1}; // [RULE7]
              FCS_OP_PW_UNLK:
                if (step == 6'd3)       cyc = '{addr: '0, data: CMD_WBUF, we: 1'b1};
                else if (step == 6'd4)  cyc = '{addr: '0, data: 8'h03, we: 1'b1};
                else if (step == 6'd13) cyc = '{addr: '0, data: CMD_COMMIT, we: 1'b1};
                else                    cyc = '{addr: unk_addr, data: wdata, we: 1'b1}; // [RULE5]
              default:
                cyc = (step == 6'd3) ? '{addr: '0, data: CMD_PROG, we: 1'b1}
                                     : '{addr: sect_base, data: (cur.op == FCS_OP_DYB_CLR) ? 8'h01 : 8'h00,
                                         we: 1'b1};
            endcase
      endcase
    end
  end

  assign req_ready  = (state == FCS_IDLE);
  assign cyc_valid  = (state == FCS_RUN);
  wire   data_beat  = (cur.op == FCS_OP_WBUF && step >= 6'd4 && step < last_step)
                   || (cur.op == FCS_OP_PW_UNLK && step >= 6'd5 && step < 6'd13);
  assign wdata_take = cyc_valid && cyc_ready && data_beat;
  // Accelerate input high across the whole protect-bit setting sequence
  assign accel_input = (state != FCS_IDLE) && (cur.op == FCS_OP_PPB_PROG || cur.op == FCS_OP_DYB_SET
                       || cur.op == FCS_OP_DYB_CLR); // [RULE6]
  wire   cyc_is_rd  = (cur.op == FCS_OP_READ) || (cur.op == FCS_OP_PW_READ && step == 6'd3)
                   || (cur.op == FCS_OP_PROT_VFY && step == 6'd3)
                   || (cur.op == FCS_OP_ID && step >= 6'd3 && step <= 6'd5);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state           <= FCS_IDLE;
      cur             <= '0;
      step            <= '0;
      rsp_valid       <= 1'b0;
      rsp_data        <= '0;
      rsp_error       <= 1'b0;
      erase_busy      <= 1'b0;
      erase_suspended <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      unique case (state)
        FCS_IDLE:
          if (req_valid)
          begin
            if (op_legal)
            begin
              cur   <= req;
              step  <= '0;
              state <= FCS_RUN;
            end
            else
              rsp_error <= 1'b1; // [RULE21] [RULE22]
          end
        FCS_RUN:
          if (cyc_ready)
            state <= FCS_WAIT;
        FCS_WAIT:
          if (cyc_done)
          begin
            if (cyc_is_rd)
            begin
              rsp_valid <= 1'b1;
              rsp_data  <= (cur.op == FCS_OP_PROT_VFY) ? {7'h00, cyc_rdata[0]} : cyc_rdata; // [RULE18]
            end
            if (step == last_step)
            begin
              state <= FCS_IDLE;
              if (cur.op == FCS_OP_SECT_ER)
                erase_busy <= 1'b1;
              if (cur.op == FCS_OP_SUSPEND)
                erase_suspended <= 1'b1;
              if (cur.op == FCS_OP_RESUME)
                erase_suspended <= 1'b0;
            end
            else
            begin
              step  <= step + 6'd1;
              state <= FCS_RUN;
            end
          end
      endcase
    end
  end

  fcs_bus_cycle u_cycle (
    .clock        (clock),
    .rst          (rst),
    .cyc_valid    (cyc_valid),
    .cyc_ready    (cyc_ready),
    .cyc          (cyc),
    .cyc_done     (cyc_done),
    .cyc_rdata    (cyc_rdata),
    .flash_addr   (flash_addr),
    .flash_ce_n   (flash_ce_n),
    .flash_we_n   (flash_we_n),
    .flash_oe_n   (flash_oe_n),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in)
  );

  a_wbuf_len_cap: assert property (@(posedge clock) disable iff (rst) // [RULE14]
    (state != FCS_IDLE && cur.op == FCS_OP_WBUF) |-> (last_step < 6'(SEQ_MAX)))
    else $error("buffer sequence too long");
  a_suspend_refused: assert property (@(posedge clock) disable iff (rst) // [RULE21]
    (req_valid && req_ready && req.op == FCS_OP_SUSPEND && !erase_busy) |=> (rsp_error && state == FCS_IDLE))
    else $error("suspend taken without running erase");
  a_resume_refused: assert property (@(posedge clock) disable iff (rst) // [RULE22]
    (req_valid && req_ready && req.op == FCS_OP_RESUME && !erase_suspended) |=> rsp_error)
    else $error("resume taken while not suspended");
  a_accel_held: assert property (@(posedge clock) disable iff (rst) // [RULE6]
    (!flash_ce_n && cur.op inside {FCS_OP_PPB_PROG, FCS_OP_DYB_SET, FCS_OP_DYB_CLR}) |-> accel_input)
    else $error("accelerate low during protect set");
  a_unlock_addr: assert property (@(posedge clock) disable iff (rst) // [RULE13]
    (!flash_we_n && step == 6'd1) |-> (flash_addr == u2 && flash_dq_out == UNLOCK_D2))
    else $error("second unlock cycle wrong");
  a_verify_bit: assert property (@(posedge clock) disable iff (rst) // [RULE18]
    (rsp_valid && cur.op == FCS_OP_PROT_VFY) |-> (rsp_data[7:1] == 7'h00))
    else $error("protect verify result not 0 or 1");
  a_exit_pair: assert property (@(posedge clock) disable iff (rst) // [RULE2]
    (cyc_valid && cur.op == FCS_OP_DYB_SET && step == last_step) |-> (cyc.data == CMD_EXIT0))
    else $error("protection set not exited");
  a_commit_last: assert property (@(posedge clock) disable iff (rst) // [RULE20]
    (cyc_valid && cur.op == FCS_OP_WBUF && step == last_step) |-> (cyc.data == CMD_COMMIT && cyc.addr == sect_base))
    else $error("buffer commit missing");

endmodule // fcs_flash_host

// ---- dv/fcs_flash_model.sv ----
`timescale 1ns/1ps
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h3a  // Arbitrary identity value
)
(
  // Flash pins from the host
  input  wire logic [fcs_pkg::ADDR_W-1:0] flash_addr,
  input  wire logic                       flash_ce_n,
  input  wire logic                       flash_we_n,
  input  wire logic                       flash_oe_n,
  input  wire logic [fcs_pkg::DATA_W-1:0] flash_dq_out,
  input  wire logic                       flash_dq_oe,
  output logic [fcs_pkg::DATA_W-1:0]      flash_dq_in
);
  logic [ADDR_W-1:0] wa [0:255];
  logic [DATA_W-1:0] wd [0:255];
  int                n = 0;
  logic              asel = 1'b0;
  logic              armed = 1'b0;
  logic [ADDR_W-1:0] la;
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] hold = 8'h00;
  wire               wr = !flash_we_n && !flash_ce_n;

  always @(posedge wr)
  begin
    la = flash_addr;
    armed = 1'b1;
  end

  // Armed flag keeps the power-up edge out of the log
  always @(negedge wr)
    if (armed)
    begin
      armed = 1'b0;
      wa[n] = la;
      // Undriven bus latches inverted, so a missing drive shows up as bad data
      wd[n] = flash_dq_oe ? ~flash_dq_out : flash_dq_out;
      if (wd[n] == 8'h90 && n > 0 && wd[n-1] == 8'h55) asel = 1'b1;
      if (wd[n] == 8'hf0 || wd[n] == 8'h00) asel = 1'b0;
      n = n + 1;
    end

  // Odd sectors read back as protected
  assign rd = !asel ? flash_addr[7:0] ^ 8'h5a :
              flash_addr[7:0] == AS_PROT ? {7'h00, flash_addr[SECT_LSB]} : ID_CODE;
  // Released bus shows the inverse so a stale value never passes
  always @(posedge flash_oe_n) hold = rd;
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd : ~hold;
endmodule // fcs_flash_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
  import fcs_pkg::*;
  logic               clock = 1'b0;
  logic               rst = 1'b1;
  logic               req_valid = 1'b0;
  fcs_req_s           req = '0;
  logic [7:0]         wsel = 8'h00;
  int                 n_fail = 0;
  int                 tests_run = 0;
  int                 n0, nrsp, nerr;
  logic               acc_seen;
  logic [7:0]         last_rd;
  wire logic          req_ready, wdata_take, rsp_valid, rsp_error, erase_busy, erase_suspended;
  wire logic          flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe, accel_input;
  wire logic [7:0]    rsp_data, flash_dq_out, flash_dq_in;
  wire logic [21:0]   flash_addr;
  wire logic [7:0]    wdata = 8'hc0 + wsel;

  always #50 clock = ~clock;
  always @(posedge clock) if (wdata_take) wsel <= wsel + 8'h01;

  fcs_flash_host fcs_flash_host_inst (.clock, .rst, .req_valid, .req_ready, .req, .wdata, .wdata_take,
    .rsp_valid, .rsp_data, .rsp_error, .erase_busy, .erase_suspended, .flash_addr, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .accel_input);
  fcs_flash_model fcs_flash_model_inst (.flash_addr, .flash_ce_n, .flash_we_n, .flash_oe_n,
    .flash_dq_out, .flash_dq_oe, .flash_dq_in);

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int nw();
    return fcs_flash_model_inst.n - n0;
  endfunction

  task automatic wchk(int k, logic [11:0] a, logic [7:0] d);
    check(fcs_flash_model_inst.wa[n0+k][11:0], a);
    check(fcs_flash_model_inst.wd[n0+k], d);
  endtask

  // Runs one request and gathers responses until one cycle after ready returns
  task automatic run(fcs_op_e op, logic [21:0] a, logic [7:0] d, logic [5:0] c);
    int i;
    int k;
    n0 = fcs_flash_model_inst.n;
    nrsp = 0;
    nerr = 0;
    k = 0;
    acc_seen = 1'b0;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{op: op, addr: a, data: d, count: c};
    @(posedge clock);
    req_valid <= 1'b0;
    for (i = 0; i < 900 && i <= k + 2; i++)
    begin
      @(negedge clock);
      if (rsp_valid === 1'b1) nrsp++;
      if (rsp_valid === 1'b1) last_rd = rsp_data;
      if (rsp_error === 1'b1) nerr++;
      if (accel_input === 1'b1) acc_seen = 1'b1;
      if (req_ready !== 1'b1) k = i;
    end
    if (i >= 900)
    begin
      n_fail++;
      $display("FAIL %0t: request never completed", $time);
      print_verdict();
    end
  endtask

  function automatic logic [7:0] wd_at(int k);
    return fcs_flash_model_inst.wd[n0+k];
  endfunction

  function automatic logic [21:0] wa_at(int k);
    return fcs_flash_model_inst.wa[n0+k];
  endfunction

  task automatic t_prog();
    run(FCS_OP_PROG, 22'h2a5123, 8'h3c, 6'h00);
    check(nw(), 4);
    wchk(0, UNLOCK_A1, UNLOCK_D1);
    wchk(1, UNLOCK_A2, UNLOCK_D2);
    wchk(2, UNLOCK_A1, CMD_PROG);
    check(wa_at(3), 22'h2a5123);
    check(wd_at(3), 8'h3c);
    check(acc_seen, 1'b0);
  endtask

  task automatic t_read();
    run(FCS_OP_READ, 22'h001234, 8'h00, 6'h00);
    check(nrsp, 1);
    check(last_rd, 8'h34 ^ 8'h5a);
    check(nw(), 0);
  endtask

  task automatic t_refuse();
    run(FCS_OP_SUSPEND, 22'h0, 8'h00, 6'h00);
    check(nerr, 1);
    check(nw(), 0);
    run(FCS_OP_RESUME, 22'h0, 8'h00, 6'h00);
    check(nerr, 1);
    check(nw(), 0);
  endtask

  task automatic t_erase();
    run(FCS_OP_SECT_ER, 22'h05a123, 8'h00, 6'h00);
    check(nw(), 6);
    wchk(2, UNLOCK_A1, CMD_ERASE);
    check(wa_at(5) >> SECT_LSB, 22'h0b);
    check(wd_at(5), CMD_SECT);
    check(erase_busy, 1'b1);
    run(FCS_OP_SUSPEND, 22'h0, 8'h00, 6'h00);
    check({nerr[1:0], wd_at(0), erase_suspended}, {2'd0, CMD_SUSPEND, 1'b1});
    run(FCS_OP_RESUME, 22'h0, 8'h00, 6'h00);
    check({nerr[1:0], wd_at(0), erase_suspended}, {2'd0, CMD_RESUME, 1'b0});
    run(FCS_OP_RESUME, 22'h0, 8'h00, 6'h00);
    check(nerr, 1);
    check(nw(), 0);
  endtask

  task automatic t_wbuf();
    @(posedge clock);
    wsel <= 8'h00;
    run(FCS_OP_WBUF, 22'h0a0010, 8'h00, 6'd2);
    check(nw(), 8);
    check(wd_at(2), CMD_WBUF);
    check(wd_at(3), 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      check(wa_at(4 + i), 22'h0a0010 + i);
      check(wd_at(4 + i), 8'hc0 + i[7:0]);
    end
    check(wa_at(7) >> SECT_LSB, 22'h14);
    check(wd_at(7), CMD_COMMIT);
    // Oversized count is clamped to a full page
    run(FCS_OP_WBUF, 22'h0a0010, 8'h00, 6'd63);
    check(nw(), SEQ_MAX);
    check(wd_at(3), 8'h1f);
  endtask

  task automatic t_prot();
    run(FCS_OP_DYB_SET, 22'h030000, 8'h00, 6'h00);
    check(acc_seen, 1'b1);
    check(wd_at(2), CMD_DYB_ENT);
    check({wd_at(nw() - 2), wd_at(nw() - 1)}, 16'h9000);
    @(posedge clock);
    wsel <= 8'h00;
    run(FCS_OP_PW_UNLK, 22'h0, 8'h00, 6'h00);
    for (int i = 0; i < 8; i++)
      wchk(5 + i, i[11:0], 8'hc0 + i[7:0]);
    check(nw(), 16);
  endtask

  task automatic t_autosel();
    run(FCS_OP_PROT_VFY, 22'h018000, 8'h00, 6'h00);
    check(last_rd, 8'h01);
    run(FCS_OP_PROT_VFY, 22'h010000, 8'h00, 6'h00);
    check(last_rd, 8'h00);
    run(FCS_OP_ID, 22'h0, 8'h00, 6'h00);
    check({nrsp[1:0], last_rd}, {2'd3, 8'h3a});
    check(nw(), 4);
    check(wd_at(nw() - 1), CMD_RESET);
  endtask

  task automatic t_misc();
    run(FCS_OP_RESET, 22'h0, 8'h00, 6'h00);
    check(nw(), 1);
    check(wd_at(0), CMD_RESET);
    run(FCS_OP_ABORT, 22'h0, 8'h00, 6'h00);
    check(nw(), 3);
    wchk(2, UNLOCK_A1, CMD_RESET);
    run(FCS_OP_PW_PROG, 22'h000003, 8'h77, 6'h00);
    check(nw(), 7);
    wchk(3, 12'h000, CMD_PROG);
    wchk(4, 12'h003, 8'h77);
    run(FCS_OP_PW_READ, 22'h000005, 8'h00, 6'h00);
    check({nrsp[1:0], last_rd}, {2'd1, 8'h05 ^ 8'h5a});
    check(nw(), 5);
    run(FCS_OP_PPB_ERA, 22'h0, 8'h00, 6'h00);
    check({wd_at(3), wd_at(4)}, {CMD_ERASE, CMD_SECT});
    run(FCS_OP_DYB_CLR, 22'h058000, 8'h00, 6'h00);
    check(acc_seen, 1'b1);
    check(wa_at(4) >> SECT_LSB, 22'h0b);
    check(wd_at(4), 8'h01);
    run(FCS_OP_CHIP_ER, 22'h0, 8'h00, 6'h00);
    wchk(5, UNLOCK_A1, CMD_CHIP);
  endtask

  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_read();
    t_prog();
    t_refuse();
    t_erase();
    t_wbuf();
    t_prot();
    t_autosel();
    t_misc();
    print_verdict();
  end
endmodule // tb
